// File: src/rct_defines.vh
// register offsets, field positions, reset values and timing counts of the reload/capture timer
// assumes inclusion by the timer source, its checker and its bench
`ifndef RCT_DEFINES_VH
`define RCT_DEFINES_VH

// register byte offsets
`define RCT_CTRL_OFS      8'h00
`define RCT_COUNT_OFS     8'h04
`define RCT_RCV_OFS       8'h08
`define RCT_STATUS_OFS    8'h0C
`define RCT_MASK_OFS      8'h10

// control field positions
`define RCT_CTRL_RUN      0
`define RCT_CTRL_EXTCNT   1
`define RCT_CTRL_CAPMODE  2
`define RCT_CTRL_UPDOWN   3
`define RCT_CTRL_TRIGEN   4
`define RCT_CTRL_TRIGRISE 5
`define RCT_CTRL_PRESC    6
`define RCT_CTRL_WIDTH    9

// status field positions
`define RCT_ST_RELOAD     0
`define RCT_ST_CAPTURE    1

// reset values
`define RCT_CTRL_RST      9'h000
`define RCT_COUNT_RST     16'h0000
`define RCT_RCV_RST       16'h0000
`define RCT_MASK_RST      2'h0

// timing: one tick per twelve clocks with the prescaler off
`define RCT_TICK_DIV      12
`define RCT_MAX_COUNT     16'hFFFF
`define RCT_ZERO_COUNT    16'h0000

`endif

// File: src/rct_sync.v
// two-flop synchroniser for a level arriving from a pin
// assumes the pin is asynchronous to hclk
`timescale 1ns/1ns
module rct_sync (
	input  wire hclk,
	input  wire hresetn,
	input  wire din,
	output reg  dout
);
	reg meta;

	// first stage is read only by the second
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// File: src/rct_timer.v
// one 16-bit reload/capture timer instance with its AHB-Lite register slave
// assumes one AHB-Lite master, word accesses, and pins asynchronous to hclk
//
// Functional notes
// - timer mode advances once every twelve clocks, prescaler off.
// - counter mode advances on each falling edge of count pin.
// - up-only auto-reload counts up from reload value, overflow at FFFF.
// - reload on overflow only, or also on chosen trigger pin edge.
// - up-count reload loads counter from reload/capture value register.
// - up-only auto-reload raises interrupt on every reload event.
// - up/down mode direction follows sampled trigger pin level.
// - up/down mode raises no interrupt on reload, overflow or underflow.
// - up/down mode counting up reloads only on overflow.
// - counting down underflows when count reaches reload/capture value.
// - down underflow reloads fixed maximum, not register contents.
// - capture mode counts up 0000 to FFFF, reloads zero.
// - capture mode copies count to register on chosen trigger edge.
// - capture mode overflow and capture events raise interrupt.
// - every mode may count clock ticks or pin edges; instances identical.
`timescale 1ns/1ns
`include "rct_defines.vh"
module rct_timer #(
	parameter TICK_DIV = `RCT_TICK_DIV
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        count_input_pin,
	input  wire        ext_trigger_pin,
	output reg         irq
);
	// registers
	reg [8:0]  ctrl;
	reg [15:0] count;
	reg [15:0] reload_capture_value;
	reg [1:0]  status;
	reg [1:0]  mask;

	// bus pipeline
	reg        wr_pend;
	reg [7:0]  wr_addr;
	reg [7:0]  rd_addr;
	reg        rd_pend;

	// prescaler and tick generation
	reg [9:0]  div_cnt;
	reg [2:0]  presc_cnt;
	reg        tick;
	reg        cnt_prev;
	reg        trig_prev;

	wire       cnt_sync;
	wire       trig_sync;

	// decode control fields
	wire run     = ctrl[`RCT_CTRL_RUN];
	wire extcnt  = ctrl[`RCT_CTRL_EXTCNT];
	wire capmode = ctrl[`RCT_CTRL_CAPMODE];
	wire updown  = ctrl[`RCT_CTRL_UPDOWN];
	wire trigen  = ctrl[`RCT_CTRL_TRIGEN];
	wire trigrs  = ctrl[`RCT_CTRL_TRIGRISE];
	wire [2:0] presc = ctrl[`RCT_CTRL_PRESC+2:`RCT_CTRL_PRESC];

	rct_sync u_sync_cnt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (count_input_pin),
		.dout    (cnt_sync)
	);

	rct_sync u_sync_trig (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (ext_trigger_pin),
		.dout    (trig_sync)
	);

	// detect chosen trigger edge between two samples
	function edge_hit;
		input prev;
		input cur;
		input rising;
		begin
			edge_hit = rising ? (!prev && cur) : (prev && !cur);
		end
	endfunction

	// integer difference cut to the divider width on purpose
	localparam integer DIV_LAST_I = TICK_DIV - 1;
	localparam [9:0]   DIV_LAST   = DIV_LAST_I[9:0];

	// divide clock by twelve
	// the prescaler stretches the base divider by 2^presc for presc up to 3 and by 8 for presc 4 to 7; presc 0 disables it
	wire div_wrap  = (div_cnt == DIV_LAST);
	wire presc_end = (presc_cnt == ((3'h1 << presc) - 3'h1)) || (presc == 3'h0);
	wire clk_tick  = div_wrap && presc_end;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt   <= 10'h000;
			presc_cnt <= 3'h0;
		end else if (!run) begin
			div_cnt   <= 10'h000;
			presc_cnt <= 3'h0;
		end else if (div_wrap) begin
			div_cnt   <= 10'h000;
			presc_cnt <= presc_end ? 3'h0 : presc_cnt + 3'h1;
		end else begin
			div_cnt <= div_cnt + 10'h001;
		end
	end

	// a pin edge is a sampled 1-to-0 step
	wire pin_fall = cnt_prev && !cnt_sync;
	always @* begin
		tick = run && (extcnt ? pin_fall : clk_tick);
	end

	// sample trigger pin once per tick
	// count pin is sampled every clock; the source honours the 24-clock limit
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_prev  <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			cnt_prev <= cnt_sync;
			if (tick)
				trig_prev <= trig_sync;
		end
	end

	wire trig_edge = tick && edge_hit(trig_prev, trig_sync, trigrs);
	wire count_up  = !updown || capmode || trig_sync;
	wire at_max    = (count == `RCT_MAX_COUNT);
	wire at_floor  = (count == reload_capture_value);

	// event decode for the counter
	reg        ev_reload;
	reg        ev_capture;
	reg [15:0] next_count;
	always @* begin
		ev_reload  = 1'b0;
		ev_capture = 1'b0;
		next_count = count;
		if (tick) begin
			if (capmode) begin
				next_count = at_max ? `RCT_ZERO_COUNT : count + 16'h0001;
				ev_reload  = at_max;
				ev_capture = trig_edge;
			end else if (count_up) begin
				ev_reload = at_max || (!updown && trigen && trig_edge);
				next_count = ev_reload ? reload_capture_value : count + 16'h0001;
			end else begin
				ev_reload  = at_floor;
				next_count = at_floor ? `RCT_MAX_COUNT : count - 16'h0001;
			end
		end
	end

	wire set_reload  = ev_reload && (capmode || !updown);
	wire set_capture = ev_capture;

	wire addr_ph = hsel && hready && htrans[1];

	// address phase capture; every transfer answers with zero wait states
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= 8'h00;
			rd_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ph && hwrite;
			rd_pend <= addr_ph && !hwrite;
			if (addr_ph) begin
				wr_addr <= haddr;
				rd_addr <= haddr;
			end
		end
	end

	// read of status clears it; a same-cycle event still wins
	wire rd_status = rd_pend && (rd_addr == `RCT_STATUS_OFS);

	// software registers, counter and capture
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl                 <= `RCT_CTRL_RST;
			count                <= `RCT_COUNT_RST;
			reload_capture_value <= `RCT_RCV_RST;
			mask                 <= `RCT_MASK_RST;
		end else begin
			count <= next_count;
			if (ev_capture)
				reload_capture_value <= count;
			if (wr_pend) begin
				case (wr_addr)
				`RCT_CTRL_OFS: begin
					ctrl <= hwdata[`RCT_CTRL_WIDTH-1:0];
				end
				`RCT_COUNT_OFS: begin
					count <= hwdata[15:0];
				end
				`RCT_RCV_OFS: begin
					if (!ev_capture)
						reload_capture_value <= hwdata[15:0];
				end
				`RCT_MASK_OFS: begin
					mask <= hwdata[1:0];
				end
				default: begin
					mask <= mask;
				end
				endcase
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= 2'h0;
		end else begin
			status[`RCT_ST_RELOAD]  <= set_reload ||
				(status[`RCT_ST_RELOAD] && !rd_status);
			status[`RCT_ST_CAPTURE] <= set_capture ||
				(status[`RCT_ST_CAPTURE] && !rd_status);
		end
	end

	// read data mux, registered so hrdata comes from a flop
	reg [31:0] next_rdata;
	always @* begin
		case (haddr)
		`RCT_CTRL_OFS:   next_rdata = {23'h0, ctrl};
		`RCT_COUNT_OFS:  next_rdata = {16'h0, next_count};
		`RCT_RCV_OFS:    next_rdata = {16'h0, reload_capture_value};
		`RCT_STATUS_OFS: next_rdata = {30'h0, status | {set_capture, set_reload}};
		`RCT_MASK_OFS:   next_rdata = {30'h0, mask};
		default:         next_rdata = 32'h0000_0000;
		endcase
	end

	// bus outputs and interrupt level
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			irq       <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ph && !hwrite)
				hrdata <= next_rdata;
			irq <= |(status & mask);
		end
	end
endmodule

// File: verification/rct_timer_sva.sv
// checker for the timer bus answer and interrupt pin
// assumes single transfers with an idle cycle between them
`timescale 1ns/1ns
`include "rct_defines.vh"
module rct_timer_sva (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [7:0]  haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        irq
);
	reg       wph;
	reg [7:0] wa;
	reg [8:0] ck;
	reg [1:0] mk;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// shadow of control and mask, written at end of data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph <= 1'b0;
			wa <= 8'h00;
			ck <= `RCT_CTRL_RST;
			mk <= `RCT_MASK_RST;
		end else begin
			wph <= hsel && htrans[1] && hwrite;
			wa <= haddr;
			if (wph && wa == `RCT_CTRL_OFS) ck <= hwdata[8:0];
			if (wph && wa == `RCT_MASK_OFS) mk <= hwdata[1:0];
		end
	end
	sequence s_rd(a);
		hsel && htrans[1] && !hwrite && haddr == a;
	endsequence
	property p_ready; hreadyout; endproperty
	property p_okay; !hresp; endproperty
	property p_hold; !(hsel && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
	property p_unmap; s_rd(8'h14) |=> hrdata == 32'h0; endproperty
	property p_irq_msk; irq |-> $past(mk) != 2'h0; endproperty
	property p_ctrl_rb; s_rd(`RCT_CTRL_OFS) ##0 !wph |=> hrdata == {23'h0, ck}; endproperty
	property p_mask_rb; s_rd(`RCT_MASK_OFS) ##0 !wph |=> hrdata == {30'h0, mk}; endproperty
	property p_stat_w; s_rd(`RCT_STATUS_OFS) |=> hrdata[31:2] == 30'h0; endproperty
	a_ready: assert property (p_ready) else $error("ready dropped");
	a_okay: assert property (p_okay) else $error("error response");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_irq_msk: assert property (p_irq_msk) else $error("irq with mask clear");
	a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback");
	a_mask_rb: assert property (p_mask_rb) else $error("mask readback");
	a_stat_w: assert property (p_stat_w) else $error("status upper bits set");
endmodule
bind rct_timer rct_timer_sva u_rct_timer_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// File: verification/rct_pin_model.sv
// outside source of the count and trigger pins
// assumes hclk as time base; levels change after a clock edge
`timescale 1ns/1ns
module rct_pin_model (
	input  wire hclk,
	input  wire run,
	input  wire trig,
	output reg  count_input_pin,
	output reg  ext_trigger_pin
);
	reg [4:0] cnt = 5'h00;
	initial count_input_pin = 1'b1;
	initial ext_trigger_pin = 1'b0;
	always @(posedge hclk) begin
		cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
		if (run && cnt == 5'h17) count_input_pin <= !count_input_pin;
		ext_trigger_pin <= trig;
	end
endmodule

// File: verification/rct_timer_bench.sv
// self-checking bench for one timer instance
// assumes the pin model stands for the outside source
`timescale 1ns/1ns
`include "rct_defines.vh"
module rct_timer_bench;
	reg        hclk = 1'b0;
	reg        hresetn = 1'b0;
	reg        hsel = 1'b0;
	reg [7:0]  haddr = 8'h00;
	reg [1:0]  htrans = 2'h0;
	reg        hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg        run = 1'b0;
	reg        trig = 1'b0;
	wire [31:0] hrdata;
	wire       hready, hresp, irq, cpin, tpin;
	reg [31:0] lo_q[$];
	reg [31:0] hi_q[$];
	reg [31:0] v, s, lo, hi;
	integer    err_total = 0;
	integer    n_tests = 0;
	integer    i;
	event      got;
	always #10 hclk = !hclk;
	rct_timer u_rct_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .count_input_pin(cpin),
		.ext_trigger_pin(tpin), .irq(irq));
	rct_pin_model u_rct_pin_model (.hclk(hclk), .run(run), .trig(trig),
		.count_input_pin(cpin), .ext_trigger_pin(tpin));
	task chk(input [39:0] nm, input [31:0] seen, input [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task wt(input integer n);
		repeat (n) @(posedge hclk);
	endtask
	// address phase held until ready, then data phase until ready
	task xf(input w, input [7:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		v = hrdata;
	endtask
	task rd(input [7:0] a, input [31:0] l, input [31:0] h);
		lo_q.push_back(l);
		hi_q.push_back(h);
		xf(1'b0, a, 32'h0);
		-> got;
	endtask
	// monitor: oldest note against each read result, range gives jitter room
	always @(got) begin
		lo = lo_q.pop_front();
		hi = hi_q.pop_front();
		chk("read", (v >= lo && v <= hi) ? lo : v, lo);
	end
	initial begin
		#200000;
		err_total = err_total + 1;
		final_report;
	end
	initial begin
		s = $urandom(69);
		wt(4);
		hresetn <= 1'b1;
		// reset values, unmapped place last
		for (i = 0; i < 6; i = i + 1) rd(8'(4 * i), 0, 0);
		xf(1, `RCT_CTRL_OFS, 1);
		wt(240);
		xf(1, `RCT_CTRL_OFS, 0);
		rd(`RCT_COUNT_OFS, 19, 21);
		xf(1, `RCT_COUNT_OFS, 0);
		xf(1, `RCT_CTRL_OFS, 3);
		run <= 1'b1;
		wt(480);
		run <= 1'b0;
		wt(60);
		xf(1, `RCT_CTRL_OFS, 0);
		rd(`RCT_COUNT_OFS, 10, 10);
		// overflow reload, irq raised and cleared
		s = $urandom % 32'hF000;
		xf(1, `RCT_RCV_OFS, s);
		xf(1, `RCT_COUNT_OFS, 32'hFFFA);
		xf(1, `RCT_MASK_OFS, 1);
		xf(1, `RCT_CTRL_OFS, 1);
		for (i = 0; i < 200 && irq !== 1'b1; i = i + 1) @(posedge hclk);
		chk("irq", irq, 1);
		xf(1, `RCT_CTRL_OFS, 0);
		rd(`RCT_COUNT_OFS, s, s + 2);
		rd(`RCT_STATUS_OFS, 1, 1);
		wt(2);
		chk("irq", irq, 0);
		xf(1, `RCT_RCV_OFS, 32'h10);
		xf(1, `RCT_COUNT_OFS, 32'h13);
		xf(1, `RCT_MASK_OFS, 3);
		xf(1, `RCT_CTRL_OFS, 9);
		wt(120);
		xf(1, `RCT_CTRL_OFS, 0);
		rd(`RCT_COUNT_OFS, 32'hFFF0, 32'hFFFF);
		trig <= 1'b1;
		xf(1, `RCT_CTRL_OFS, 9);
		wt(120);
		xf(1, `RCT_CTRL_OFS, 0);
		rd(`RCT_COUNT_OFS, 32'h10, 32'h1A);
		rd(`RCT_STATUS_OFS, 0, 0);
		chk("irq", irq, 0);
		// capture on rising edge, irq masked
		trig <= 1'b0;
		xf(1, `RCT_MASK_OFS, 0);
		xf(1, `RCT_COUNT_OFS, 32'hFFFC);
		xf(1, `RCT_CTRL_OFS, 32'h25);
		wt(120);
		trig <= 1'b1;
		wt(60);
		xf(1, `RCT_CTRL_OFS, 0);
		rd(`RCT_RCV_OFS, 4, 32'hF);
		rd(`RCT_STATUS_OFS, 3, 3);
		chk("irq", irq, 0);
		// up-only reload on falling trigger edge
		xf(1, `RCT_RCV_OFS, 32'h100);
		xf(1, `RCT_COUNT_OFS, 0);
		xf(1, `RCT_CTRL_OFS, 32'h11);
		wt(60);
		trig <= 1'b0;
		wt(30);
		xf(1, `RCT_CTRL_OFS, 0);
		rd(`RCT_COUNT_OFS, 32'h100, 32'h103);
		rd(`RCT_STATUS_OFS, 1, 1);
		wt(4);
		final_report;
	end
endmodule
